// ==== logic/csr_chip_select.sv ====
// Chip-select core: reset straps, select registers, cycle response
// Operation
// - Select acknowledge answers only interrupts raised on external pins.
// - Internally raised acknowledge gets no select response at all.
// - Unvectored acknowledge ends by external or internal autovector.
// - General pin field LSB resets one, MSB from data line strap.
// - Weak pull-ups on data lines default to select function.
// - General select byte fields reset to disabled.
// - General selects reset to base zero, 2K, async, all off.
// - Boot base resets to zero with 512 Kbyte block.
// - Boot pin field MSB resets to one.
// - Boot byte field resets to both bytes.
// - Boot port width from data line 0 strap, default 16-bit.
// - Boot options reset async, read/write, 13 waits, supervisor.
// - Priority and autovector fields ignored unless space is CPU.
// - Select asserts with strobe async, with slow clock sync.
`timescale 1ns/1ps
module csr_chip_select #(
  parameter int ECLK_DIV = 8              // Slow bus clock divide ratio
) (
  input wire logic clk_sys_i,             // System clock
  input wire logic rst_i,                 // Synchronous reset
  input wire logic [7:0] data_pin_i,      // Data pins, strap levels
  output logic data_pullup_o,             // Weak pull-up enable
  input wire logic cfg_wr_i,              // Register write strobe
  input wire logic [3:0] cfg_idx_i,       // Select index, 11 is boot
  input wire logic [12:0] cfg_base_i,     // Base address write data
  input wire logic [2:0] cfg_blksz_i,     // Block size write data
  input wire logic [15:0] cfg_opt_i,      // Option word write data
  input wire logic [1:0] cfg_pin_i,       // Pin field write data
  output logic [12:0] rd_base_o,          // Base readback
  output logic [2:0] rd_blksz_o,          // Block size readback
  output logic [15:0] rd_opt_o,           // Option readback
  output logic [1:0] rd_pin_o,            // Pin field readback
  input wire logic as_i,                  // Address strobe
  input wire logic ds_i,                  // Data strobe
  input wire logic [23:0] addr_i,         // Cycle address
  input wire logic [2:0] fc_i,            // Function code
  input wire logic rw_i,                  // High for read
  input wire logic [1:0] siz_i,           // Transfer size
  input wire logic iack_internal_i,       // Internal module owns iack
  output logic [11:0] cs_n_o,             // Select outputs, active low
  output logic eclk_o,                    // Slow bus clock
  output logic autovector_request_o,                    // Autovector pulse
  output logic ack_o,                     // Transfer ack pulse
  output logic ack_port16_o               // Ack is for a 16-bit port
);
  localparam int N = csr_pkg::NUM_SEL;
  localparam int CW = $clog2(ECLK_DIV);
  localparam logic [CW-1:0] DIV_LAST = CW'(ECLK_DIV - 1);
  localparam logic [CW-1:0] DIV_HALF = CW'(ECLK_DIV / 2);

  typedef enum logic [1:0] {S_IDLE, S_ACTIVE, S_END} csr_state_t;

  // Strap synchroniser and capture
  logic [7:0] data_m;
  logic [7:0] data_q;
  logic [7:0] strap;
  logic [7:0] next_strap;

  assign data_pullup_o = 1'b1;

  always_comb begin
    next_strap = rst_i ? data_q : strap;
  end

  always_ff @(posedge clk_sys_i) begin
    data_m <= data_pin_i;
    data_q <= data_m;
    strap <= next_strap;
  end

  // Select registers
  logic [12:0] base_r [N];
  logic [2:0] blksz_r [N];
  logic [15:0] opt_r [N];
  logic [1:0] pin_r [N];
  logic [12:0] next_base [N];
  logic [2:0] next_blksz [N];
  logic [15:0] next_opt [N];
  logic [1:0] next_pin [N];
  logic [12:0] next_rd_base;
  logic [2:0] next_rd_blksz;
  logic [15:0] next_rd_opt;
  logic [1:0] next_rd_pin;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_base[i] = base_r[i];
      next_blksz[i] = blksz_r[i];
      next_opt[i] = opt_r[i];
      next_pin[i] = pin_r[i];
      if (rst_i) begin
        next_base[i] = csr_pkg::BASE_RST;
        if (i == csr_pkg::BOOT_IDX) begin
          next_blksz[i] = csr_pkg::BLKSZ_512K;
          next_opt[i] = csr_pkg::BOOT_OPT_RST;
          next_pin[i] = {1'b1, data_q[0]};
        end else begin
          next_blksz[i] = csr_pkg::BLKSZ_2K;
          next_opt[i] = csr_pkg::GEN_OPT_RST;
          next_pin[i] = {data_q[(i % 7) + 1], 1'b1};
        end
      end else if (cfg_wr_i && cfg_idx_i == 4'(i)) begin
        next_base[i] = cfg_base_i;
        next_blksz[i] = cfg_blksz_i;
        next_opt[i] = cfg_opt_i;
        next_pin[i] = cfg_pin_i;
      end
    end
    next_rd_base = 13'h0000;
    next_rd_blksz = 3'h0;
    next_rd_opt = 16'h0000;
    next_rd_pin = 2'h0;
    if (!rst_i && cfg_idx_i < 4'(N)) begin
      next_rd_base = base_r[cfg_idx_i];
      next_rd_blksz = blksz_r[cfg_idx_i];
      next_rd_opt = opt_r[cfg_idx_i];
      next_rd_pin = pin_r[cfg_idx_i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    base_r <= next_base;
    blksz_r <= next_blksz;
    opt_r <= next_opt;
    pin_r <= next_pin;
    rd_base_o <= next_rd_base;
    rd_blksz_o <= next_rd_blksz;
    rd_opt_o <= next_rd_opt;
    rd_pin_o <= next_rd_pin;
  end

  // Slow bus clock divider
  logic [CW-1:0] div_cnt;
  logic [CW-1:0] next_div_cnt;
  logic eclk_en;
  logic next_eclk;

  always_comb begin
    eclk_en = (div_cnt == DIV_LAST);
    next_div_cnt = eclk_en ? '0 : CW'(div_cnt + 1'b1);
    next_eclk = (next_div_cnt < DIV_HALF);
    if (rst_i) begin
      next_div_cnt = '0;
      next_eclk = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    div_cnt <= next_div_cnt;
    eclk_o <= next_eclk;
  end

  // Comparators
  logic [N-1:0] hit;
  logic [N-1:0] av;

  for (genvar g = 0; g < N; g++) begin : g_match
    csr_select_match u_match (
      .base_i(base_r[g]),
      .blksz_i(blksz_r[g]),
      .opt_i(opt_r[g]),
      .pin_i(pin_r[g]),
      .addr_i(addr_i),
      .fc_i(fc_i),
      .rw_i(rw_i),
      .siz_i(siz_i),
      .iack_ext_i(!iack_internal_i),
      .hit_o(hit[g]),
      .autovector_request_o(av[g])
    );
  end

  // Cycle response
  csr_state_t state;
  csr_state_t next_state;
  logic [N-1:0] hit_q;
  logic [N-1:0] next_hit_q;
  logic [3:0] win;
  logic [3:0] next_win;
  logic win_ok;
  logic next_win_ok;
  logic av_q;
  logic next_av_q;
  logic [3:0] wait_q;
  logic [3:0] next_wait_q;
  logic int_q;
  logic next_int_q;
  logic cpu_q;
  logic next_cpu_q;
  logic [N-1:0] next_cs_n;
  logic next_autovector_request;
  logic next_ack;
  logic next_port16;
  logic [3:0] first;
  logic [3:0] transfer_size_ack_w;
  logic [3:0] transfer_size_ack_q;

  always_comb begin
    first = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        first = 4'(i);
      end
    end
    transfer_size_ack_w = opt_r[first][csr_pkg::OPT_TRANSFER_SIZE_ACK_LO +: 4];
    transfer_size_ack_q = opt_r[win][csr_pkg::OPT_TRANSFER_SIZE_ACK_LO +: 4];
    next_state = state;
    next_hit_q = hit_q;
    next_win = win;
    next_win_ok = win_ok;
    next_av_q = av_q;
    next_wait_q = wait_q;
    next_int_q = int_q;
    next_cpu_q = cpu_q;
    next_autovector_request = 1'b0;
    next_ack = 1'b0;
    next_port16 = ack_port16_o;
    unique case (state)
      S_IDLE: begin
        if (as_i) begin
          next_state = S_ACTIVE;
          next_hit_q = hit;
          next_win = first;
          next_win_ok = |hit;
          next_av_q = av[first];
          next_wait_q = (transfer_size_ack_w == csr_pkg::TRANSFER_SIZE_ACK_FAST) ? 4'h0 : transfer_size_ack_w;
          next_int_q = iack_internal_i;
          next_cpu_q = (fc_i == csr_pkg::FC_CPU);
        end
      end
      S_ACTIVE: begin
        if (!as_i) begin
          next_state = S_IDLE;
        end else if (win_ok && av_q) begin
          next_autovector_request = 1'b1;
          next_state = S_END;
        end else if (win_ok && transfer_size_ack_q != csr_pkg::TRANSFER_SIZE_ACK_EXT) begin
          if (wait_q == 4'h0) begin
            next_ack = 1'b1;
            next_port16 = pin_r[win][0];
            next_state = S_END;
          end else begin
            next_wait_q = wait_q - 4'h1;
          end
        end
      end
      S_END: begin
        if (!as_i) begin
          next_state = S_IDLE;
        end
      end
    endcase
    for (int i = 0; i < N; i++) begin
      next_cs_n[i] = 1'b1;
      if (state != S_IDLE && as_i && hit_q[i]) begin
        if (opt_r[i][csr_pkg::OPT_MODE]) begin
          next_cs_n[i] = !(eclk_en || !cs_n_o[i]);
        end else begin
          next_cs_n[i] = opt_r[i][csr_pkg::OPT_STRB] ? !ds_i : 1'b0;
        end
      end
    end
    if (rst_i) begin
      next_state = S_IDLE;
      next_hit_q = '0;
      next_win_ok = 1'b0;
      next_av_q = 1'b0;
      next_int_q = 1'b0;
      next_cpu_q = 1'b0;
      next_cs_n = '1;
      next_autovector_request = 1'b0;
      next_ack = 1'b0;
      next_port16 = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    state <= next_state;
    hit_q <= next_hit_q;
    win <= next_win;
    win_ok <= next_win_ok;
    av_q <= next_av_q;
    wait_q <= next_wait_q;
    int_q <= next_int_q;
    cpu_q <= next_cpu_q;
    cs_n_o <= next_cs_n;
    autovector_request_o <= next_autovector_request;
    ack_o <= next_ack;
    ack_port16_o <= next_port16;
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic gen_byte_any;
  logic gen_rst_ok;
  logic pin_rst_ok;
  always_comb begin
    gen_byte_any = 1'b0;
    gen_rst_ok = 1'b1;
    pin_rst_ok = 1'b1;
    for (int i = 0; i < csr_pkg::NUM_GEN; i++) begin
      gen_byte_any |= |opt_r[i][csr_pkg::OPT_BYTE_LO +: 2];
      gen_rst_ok &= (opt_r[i] == 16'h0000) && (blksz_r[i] == 3'h0) &&
                    (base_r[i] == 13'h0000);
      pin_rst_ok &= (pin_r[i] == {strap[(i % 7) + 1], 1'b1});
    end
  end

  sequence rst_release;
    $fell(rst_i);
  endsequence

  chk_gen_byte_off: assert property (rst_release |-> !gen_byte_any)
    else $error("general byte field not disabled after reset");
  chk_gen_reset_vals: assert property (rst_release |-> gen_rst_ok)
    else $error("general select reset values wrong");
  chk_pin_strap: assert property (rst_release |-> pin_rst_ok)
    else $error("pin field does not follow strap");
  chk_boot_base: assert property (rst_release |->
    base_r[11] == 13'h0000 && blksz_r[11] == 3'h6)
    else $error("boot base not zero with 512K block");
  chk_boot_pin_width: assert property (rst_release |->
    pin_r[11] == {1'b1, strap[0]})
    else $error("boot pin field wrong after reset");
  chk_boot_opts: assert property (rst_release |->
    opt_r[11] == 16'h7b60)
    else $error("boot option reset value wrong");
  chk_strap_hold: assert property (!$past(rst_i) |-> $stable(strap))
    else $error("strap changed outside reset");
  chk_internal_quiet: assert property (
    (state != S_IDLE && int_q && cpu_q) |=>
    (&cs_n_o) && !autovector_request_o && !ack_o)
    else $error("select answered internal acknowledge");
  chk_autovector_request_cause: assert property (
    autovector_request_o |-> !int_q && cpu_q && !$past(autovector_request_o))
    else $error("autovector without external acknowledge");
  chk_cs_strobe: assert property (!(&cs_n_o) |-> $past(as_i))
    else $error("select asserted without address strobe");
endmodule : csr_chip_select

// ==== logic/csr_select_match.sv ====
// Shared constants and the per-select address and attribute comparator
`timescale 1ns/1ps
package csr_pkg;
  localparam int NUM_GEN = 11;
  localparam int NUM_SEL = 12;
  localparam int BOOT_IDX = 11;
  localparam int IDX_W = 4;
  localparam int BASE_W = 13;
  localparam int OPT_W = 16;
  // Option word field positions
  localparam int OPT_MODE = 15;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_LO = 11;
  localparam int OPT_STRB = 10;
  localparam int OPT_TRANSFER_SIZE_ACK_LO = 6;
  localparam int OPT_SPACE_LO = 4;
  localparam int OPT_IPL_LO = 1;
  localparam int OPT_AUTOVECTOR_REQUEST = 0;
  // Reset values
  localparam logic [12:0] BASE_RST = 13'h0000;
  localparam logic [2:0] BLKSZ_2K = 3'h0;
  localparam logic [2:0] BLKSZ_512K = 3'h6;
  localparam logic [15:0] GEN_OPT_RST = 16'h0000;
  localparam logic [15:0] BOOT_OPT_RST = 16'h7b60;
  // Field encodings
  localparam logic [1:0] BYTE_OFF = 2'h0;
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h1;
  localparam logic [1:0] SPACE_SUPER = 2'h2;
  localparam logic [1:0] SPACE_ANY = 2'h3;
  localparam logic [3:0] WAIT_13 = 4'hd;
  localparam logic [3:0] TRANSFER_SIZE_ACK_FAST = 4'he;
  localparam logic [3:0] TRANSFER_SIZE_ACK_EXT = 4'hf;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [3:0] IACK_TYPE = 4'hf;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
endpackage : csr_pkg

module csr_select_match (
  input wire logic [12:0] base_i,   // Base address bits 23..11
  input wire logic [2:0] blksz_i,   // Block size code
  input wire logic [15:0] opt_i,    // Option word
  input wire logic [1:0] pin_i,     // Pin assignment field
  input wire logic [23:0] addr_i,   // Cycle address
  input wire logic [2:0] fc_i,      // Function code
  input wire logic rw_i,            // High for read
  input wire logic [1:0] siz_i,     // Transfer size
  input wire logic iack_ext_i,      // Acknowledge owned by external pin
  output logic hit_o,               // Full match
  output logic autovector_request_o               // Match wants autovector
);
  // Compare mask over addr bits 23..11 per block size code
  function automatic logic [12:0] blk_mask(input logic [2:0] code);
    unique case (code)
      3'h0: blk_mask = 13'h1fff;
      3'h1: blk_mask = 13'h1ffc;
      3'h2: blk_mask = 13'h1ff8;
      3'h3: blk_mask = 13'h1fe0;
      3'h4: blk_mask = 13'h1fc0;
      3'h5: blk_mask = 13'h1f80;
      3'h6: blk_mask = 13'h1f00;
      default: blk_mask = 13'h1e00;
    endcase
  endfunction : blk_mask

  logic [1:0] byte_f;
  logic [1:0] rw_f;
  logic [1:0] space_f;
  logic [2:0] ipl_f;
  logic cpu_cyc;
  logic iack_cyc;
  logic addr_ok;
  logic space_ok;
  logic rw_ok;
  logic byte_ok;
  logic ipl_ok;
  logic lower_hit;

  always_comb begin
    byte_f = opt_i[csr_pkg::OPT_BYTE_LO +: 2];
    rw_f = opt_i[csr_pkg::OPT_RW_LO +: 2];
    space_f = opt_i[csr_pkg::OPT_SPACE_LO +: 2];
    ipl_f = opt_i[csr_pkg::OPT_IPL_LO +: 3];
    cpu_cyc = (fc_i == csr_pkg::FC_CPU);
    iack_cyc = cpu_cyc && (addr_i[19:16] == csr_pkg::IACK_TYPE);
    addr_ok = ((addr_i[23:11] ^ base_i) & blk_mask(blksz_i)) == 13'h0000;
    unique case (space_f)
      csr_pkg::SPACE_CPU: space_ok = cpu_cyc;
      csr_pkg::SPACE_USER: space_ok = !cpu_cyc && !fc_i[2];
      csr_pkg::SPACE_SUPER: space_ok = !cpu_cyc && fc_i[2];
      default: space_ok = !cpu_cyc;
    endcase
    unique case (rw_f)
      csr_pkg::RW_READ: rw_ok = rw_i;
      csr_pkg::RW_WRITE: rw_ok = !rw_i;
      csr_pkg::RW_BOTH: rw_ok = 1'b1;
      default: rw_ok = 1'b0;
    endcase
    lower_hit = addr_i[0] || (siz_i != csr_pkg::SIZ_BYTE);
    if (!pin_i[0]) begin
      byte_ok = (byte_f != csr_pkg::BYTE_OFF);
    end else begin
      unique case (byte_f)
        csr_pkg::BYTE_LOWER: byte_ok = lower_hit;
        csr_pkg::BYTE_UPPER: byte_ok = !addr_i[0];
        csr_pkg::BYTE_BOTH: byte_ok = 1'b1;
        default: byte_ok = 1'b0;
      endcase
    end
    // Priority and autovector fields only count for CPU space
    if (space_f == csr_pkg::SPACE_CPU) begin
      ipl_ok = iack_cyc && iack_ext_i &&
               (ipl_f == 3'h0 || ipl_f == addr_i[3:1]);
    end else begin
      ipl_ok = 1'b1;
    end
    hit_o = pin_i[1] && addr_ok && space_ok && rw_ok && byte_ok && ipl_ok;
    autovector_request_o = hit_o && (space_f == csr_pkg::SPACE_CPU) &&
             opt_i[csr_pkg::OPT_AUTOVECTOR_REQUEST];
  end
endmodule : csr_select_match

// ==== verif/csr_ext_bus_model.sv ====
// External bus side: strap drivers and weak pull-up resolution
`timescale 1ns/1ps
module csr_ext_bus_model (
  input wire logic clk_sys_i,      // System clock
  input wire logic drive_i,        // Strap driver active
  input wire logic [7:0] strap_i,  // Strap levels to drive
  input wire logic pullup_i,       // Device weak pull-up enable
  output logic [7:0] data_o        // Resolved data line levels
);
  logic [7:0] toggle;

  // Floating lines wander so a missing pull-up cannot pass by luck
  always_ff @(posedge clk_sys_i) begin
    toggle <= (toggle === 8'h5a) ? 8'ha5 : 8'h5a;
  end

  always_comb begin
    if (drive_i) begin
      data_o = strap_i;
    end else if (pullup_i) begin
      data_o = 8'hff;
    end else begin
      data_o = toggle;
    end
  end
endmodule : csr_ext_bus_model

// ==== verif/tb_csr_chip_select.sv ====
// Self-checking bench for the chip-select core
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("FAIL t=%0t %s", $time, msg); \
    end \
  end
module tb_csr_chip_select;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic [7:0] data_pin_i;
  logic data_pullup_o;
  logic cfg_wr_i = 1'b0;
  logic [3:0] cfg_idx_i = 4'h0;
  logic [12:0] cfg_base_i = 13'h0000;
  logic [2:0] cfg_blksz_i = 3'h0;
  logic [15:0] cfg_opt_i = 16'h0000;
  logic [1:0] cfg_pin_i = 2'h0;
  logic [12:0] rd_base_o;
  logic [2:0] rd_blksz_o;
  logic [15:0] rd_opt_o;
  logic [1:0] rd_pin_o;
  logic as_i = 1'b0;
  logic ds_i = 1'b0;
  logic [23:0] addr_i = 24'h000000;
  logic [2:0] fc_i = 3'h0;
  logic rw_i = 1'b1;
  logic [1:0] siz_i = 2'h0;
  logic iack_internal_i = 1'b0;
  logic [11:0] cs_n_o;
  logic eclk_o;
  logic autovector_request_o;
  logic ack_o;
  logic ack_port16_o;
  logic strap_drv = 1'b1;
  logic [7:0] strap_val = 8'hff;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int k_cs, k_av, k_ack, sel, w, dsd;
  logic p16, md, sb, av, p8;
  logic [11:0] cs1;
  logic [7:0] s;
  logic [12:0] b;
  logic [2:0] lv, ip;
  logic [23:0] ia;
  int hi_n, rise_n;
  logic e_prev;
  localparam int TB_DIV = 4;

  csr_chip_select #(.ECLK_DIV(TB_DIV)) u_csr_chip_select (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .data_pin_i(data_pin_i),
    .data_pullup_o(data_pullup_o), .cfg_wr_i(cfg_wr_i),
    .cfg_idx_i(cfg_idx_i), .cfg_base_i(cfg_base_i),
    .cfg_blksz_i(cfg_blksz_i), .cfg_opt_i(cfg_opt_i),
    .cfg_pin_i(cfg_pin_i), .rd_base_o(rd_base_o),
    .rd_blksz_o(rd_blksz_o), .rd_opt_o(rd_opt_o), .rd_pin_o(rd_pin_o),
    .as_i(as_i), .ds_i(ds_i), .addr_i(addr_i), .fc_i(fc_i), .rw_i(rw_i),
    .siz_i(siz_i), .iack_internal_i(iack_internal_i), .cs_n_o(cs_n_o),
    .eclk_o(eclk_o), .autovector_request_o(autovector_request_o), .ack_o(ack_o),
    .ack_port16_o(ack_port16_o)
  );

  csr_ext_bus_model u_csr_ext_bus_model (
    .clk_sys_i(clk_sys_i), .drive_i(strap_drv), .strap_i(strap_val),
    .pullup_i(data_pullup_o), .data_o(data_pin_i)
  );

  always #12.5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("FAIL t=%0t run did not finish", $time);
      finish_test();
    end
  end

  function automatic logic [15:0] mk_opt(input logic m, input logic [1:0] y,
    input logic [1:0] r, input logic t, input logic [3:0] d,
    input logic [1:0] p, input logic [2:0] l, input logic a);
    return {m, y, r, t, d, p, l, a};
  endfunction : mk_opt

  function automatic logic [1:0] exp_pin(input int i, input logic [7:0] v);
    if (i == csr_pkg::BOOT_IDX) begin
      return {1'b1, v[0]};
    end
    return {v[(i % 7) + 1], 1'b1};
  endfunction : exp_pin

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic wsel(input int i, input logic [12:0] bb,
    input logic [2:0] z, input logic [15:0] o, input logic [1:0] p);
    @(negedge clk_sys_i);
    cfg_wr_i = 1'b1;
    cfg_idx_i = 4'(i);
    cfg_base_i = bb;
    cfg_blksz_i = z;
    cfg_opt_i = o;
    cfg_pin_i = p;
    @(negedge clk_sys_i);
    cfg_wr_i = 1'b0;
  endtask : wsel

  // Three edges of reset cover the two strap sync flops plus capture
  task automatic do_reset(input logic drv, input logic [7:0] v);
    @(negedge clk_sys_i);
    strap_drv = drv;
    strap_val = v;
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    strap_drv = 1'b0;
  endtask : do_reset

  task automatic chk_rst(input logic [7:0] v);
    logic bt;
    for (int i = 0; i < csr_pkg::NUM_SEL; i++) begin
      bt = (i == csr_pkg::BOOT_IDX);
      cfg_idx_i = 4'(i);
      repeat (2) @(negedge clk_sys_i);
      `CHK(rd_base_o, csr_pkg::BASE_RST, "base reset")
      `CHK(rd_blksz_o, bt ? csr_pkg::BLKSZ_512K : csr_pkg::BLKSZ_2K,
        "block size reset")
      `CHK(rd_opt_o, bt ? csr_pkg::BOOT_OPT_RST : csr_pkg::GEN_OPT_RST,
        "option reset")
      `CHK(rd_pin_o, exp_pin(i, v), "pin field reset")
    end
  endtask : chk_rst

  task automatic run_cyc(input int sl, input logic [23:0] a,
    input logic [2:0] f, input logic [1:0] sz, input logic intl,
    input int dd);
    @(negedge clk_sys_i);
    k_cs = -1;
    k_av = -1;
    k_ack = -1;
    addr_i = a;
    fc_i = f;
    siz_i = sz;
    iack_internal_i = intl;
    as_i = 1'b1;
    ds_i = (dd == 0);
    for (int k = 0; k < 20; k++) begin
      @(negedge clk_sys_i);
      if (k == 1) cs1 = cs_n_o;
      if (k_cs < 0 && cs_n_o[sl] === 1'b0) k_cs = k;
      if (k_av < 0 && autovector_request_o === 1'b1) k_av = k;
      if (k_ack < 0 && ack_o === 1'b1) begin
        k_ack = k;
        p16 = ack_port16_o;
      end
      if (k + 1 == dd) ds_i = 1'b1;
    end
    as_i = 1'b0;
    ds_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    `CHK(cs_n_o, 12'hfff, "select not released")
  endtask : run_cyc

  initial begin
    void'($urandom(32'hb99a4e6f));
    // Driven straps with width bit low and high, then bare pull-ups
    for (int r = 0; r < 3; r++) begin
      s = (r == 2) ? 8'hff : ((8'($urandom()) & 8'hfe) | 8'(r));
      do_reset(r != 2, s);
      `CHK(data_pullup_o, 1'b1, "pull-up off")
      chk_rst(s);
      // Slow clock: half high, one rise per divide ratio
      hi_n = 0;
      rise_n = 0;
      e_prev = eclk_o;
      for (int k = 0; k < 8; k++) begin
        @(negedge clk_sys_i);
        hi_n += int'(eclk_o === 1'b1);
        rise_n += int'(eclk_o === 1'b1 && e_prev === 1'b0);
        e_prev = eclk_o;
      end
      `CHK(hi_n, 8 / 2, "slow clock duty")
      `CHK(rise_n, 8 / TB_DIV, "slow clock period")
      run_cyc(11, {5'h00, 19'($urandom()) & 19'h7fffe}, 3'h6, 2'h2, 0, 0);
      `CHK(k_cs, 1, "boot select timing")
      `CHK(cs1[10:0], 11'h7ff, "general select out of reset")
      `CHK(k_ack, 1 + int'(csr_pkg::WAIT_13), "boot wait states")
      `CHK(p16, s[0], "boot port width")
      `CHK(k_av, -1, "boot autovector")
      $display("reset test %0d done", r);
    end
    for (int t = 0; t < 8; t++) begin
      sel = $urandom_range(0, 10);
      w = $urandom_range(0, 13);
      md = 1'($urandom());
      sb = 1'($urandom());
      av = 1'($urandom());
      b = {1'b1, 12'($urandom())};
      wsel(sel, b, 3'h0, mk_opt(md, csr_pkg::BYTE_BOTH, csr_pkg::RW_BOTH,
        sb, 4'(w), csr_pkg::SPACE_SUPER, 3'h0, av), 2'h3);
      dsd = (sb && !md) ? $urandom_range(1, 4) : 0;
      run_cyc(sel, {b, 11'($urandom()) & 11'h7fe}, 3'h5, 2'h2, 0, dsd);
      if (md) `CHK(k_cs >= 1 && k_cs <= 5, 1'b1, "sync select")
      else `CHK(k_cs, (dsd > 0) ? dsd : 1, "async select timing")
      if (!md) `CHK(k_ack, 1 + w, "wait states")
      `CHK(k_av, -1, "autovector outside CPU space")
      // Acknowledge select set up as software must
      lv = 3'($urandom_range(1, 7));
      ip = 1'($urandom()) ? lv : 3'h0;
      p8 = t[0];
      wsel(sel, 13'h1fff, 3'h3, mk_opt(1'b0, p8 ? csr_pkg::BYTE_UPPER :
        csr_pkg::BYTE_LOWER, csr_pkg::RW_READ, 1'b0, csr_pkg::TRANSFER_SIZE_ACK_EXT,
        csr_pkg::SPACE_CPU, ip, 1'b1), {1'b1, !p8});
      ia = {20'hfffff, lv, 1'b1};
      run_cyc(sel, ia, csr_pkg::FC_CPU, csr_pkg::SIZ_BYTE, 0, 0);
      `CHK(k_cs, 1, "external iack select")
      `CHK(k_av, 1, "external iack autovector")
      `CHK(k_ack, -1, "iack ack with external source")
      run_cyc(sel, ia, csr_pkg::FC_CPU, csr_pkg::SIZ_BYTE, 1, 0);
      `CHK(k_cs, -1, "internal iack select")
      `CHK(k_av, -1, "internal iack autovector")
      `CHK(k_ack, -1, "internal iack ack")
      wsel(sel, 13'h0000, 3'h0, csr_pkg::GEN_OPT_RST, 2'h3);
      $display("cycle test %0d done", t);
    end
    finish_test();
  end
endmodule : tb_csr_chip_select
